// ### pkg/pesc_cfg.svh
/*
 Register offsets, field positions, reset values and widths for the PHY
 extended status and counter register bank.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef PESC_CFG_SVH
`define PESC_CFG_SVH

// ====================================================================
// register offsets (byte address = index * 4)
`define PESC_IDX_GSTAT 5'h11
`define PESC_IDX_BYP 5'h12
`define PESC_IDX_RXERR 5'h13
`define PESC_IDX_FCAR 5'h14
`define PESC_IDX_LDROP 5'h15
`define PESC_IDX_TENC 5'h16
`define PESC_IDX_IRQ_STAT 5'h18
`define PESC_IDX_IRQ_MASK 5'h19

// ====================================================================
// reset values, writable masks and counter saturation value
`define PESC_BYP_RST 16'h0088
`define PESC_BYP_WMASK 16'hFEFE
`define PESC_TENC_RST 16'h3200
`define PESC_TENC_WMASK 16'hFE06
`define PESC_CNT_MAX 8'hFF

// ====================================================================
// bypass control field positions
`define PESC_BYP_TXDIS 15
`define PESC_BYP_4B5B 14
`define PESC_BYP_SCR 13
`define PESC_BYP_DSCR 12
`define PESC_BYP_CSRX 11
`define PESC_BYP_CSTX 10
`define PESC_BYP_LFIT 9
`define PESC_BYP_XFORCE 7
`define PESC_BYP_LEGDIS 6
`define PESC_BYP_MDIXDIS 5
`define PESC_BYP_POLDIS 4
`define PESC_BYP_HONOR 3
`define PESC_BYP_PSFDIS 2
`define PESC_BYP_NPDIS 1

// ====================================================================
// ten megabit control field positions
`define PESC_TEN_LIDIS 15
`define PESC_TEN_JABDIS 14
`define PESC_TEN_ECHODIS 13
`define PESC_TEN_SQEDIS 12
`define PESC_TEN_SQ_HI 11
`define PESC_TEN_SQ_LO 10
`define PESC_TEN_STICKY 9
`define PESC_TEN_CS_HI 2
`define PESC_TEN_CS_LO 1

// interrupt status bits
`define PESC_IRQ_W 4

`endif

// ### pkg/pesc_pkg.sv
/*
 Types for the PHY extended status and counter register bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pesc_pkg;
	// ================================================================
	// carrier sense derivation modes
	typedef enum logic [1:0] {
		PESC_CS_RX_OR_HDXTX = 2'b00,
		PESC_CS_ANY_HDX = 2'b01,
		PESC_CS_RX_ONLY = 2'b10,
		PESC_CS_RX_HDX = 2'b11
	} pesc_cs_e;

	// squelch threshold selection
	typedef enum logic [1:0] {
		PESC_SQ_NOMINAL = 2'b00,
		PESC_SQ_REDUCED = 2'b01,
		PESC_SQ_RAISED = 2'b10,
		PESC_SQ_RSVD = 2'b11
	} pesc_sq_e;

	// bus slave state
	typedef enum logic [0:0] {
		PESC_ST_IDLE = 1'b0,
		PESC_ST_ACK = 1'b1
	} pesc_state_e;
endpackage
`default_nettype wire

// ### design/pesc_regs.sv
/*
 PHY extended status, bypass control, error counters and 10 Mb/s control,
 reached over a classic Wishbone slave with 32-bit data.
 Assumes all PHY event inputs are one-cycle pulses synchronous to clk.
*/
// Implementation choice: register access over Wishbone.
// Function
// - saturating receive error counter, clear on read
// - saturating false carrier counter, clear on read
// - saturating link drop counter, clear on read
// - gigabit error flags latch, clear on read
// - lock and link status live, read-only
// - crossover and legacy partner indications read-only
// - transmit disable and bypass controls drive datapath
// - forced speed disables crossover, default set
// - separate polarity, crossover, legacy detect disables
// - parallel detect honors abilities when bit set
// - bit 2 disables transmit pulse shaping
// - bit 1 suppresses gigabit next pages
// - ten megabit disable controls with defaults
// - squelch threshold two-bit select, default nominal
// - carrier sense derived per two-bit mode
`timescale 1ns/10ps
`default_nettype none
`include "pesc_cfg.svh"

module pesc_regs
	import pesc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// phy event and status inputs
	input wire logic gig_link_up,
	input wire logic fast_link_up,
	input wire logic gig_dscr_locked,
	input wire logic gig_dscr_lock_err,
	input wire logic gig_link_disc,
	input wire logic gig_rx_err,
	input wire logic gig_tx_err,
	input wire logic gig_ssd_err,
	input wire logic gig_esd_err,
	input wire logic gig_cext_err,
	input wire logic legacy_partner_det,
	input wire logic mdi_xover_err,
	input wire logic rx_err_evt,
	input wire logic false_carrier_evt,
	input wire logic link_drop_evt,
	input wire logic ten_eof_err,
	input wire logic ten_disc,
	input wire logic ten_link_up,
	input wire logic speed_forced,
	input wire logic receiving,
	input wire logic transmitting,
	input wire logic full_duplex_flag,
	// control outputs to the datapath, and interrupt request
	output logic tx_media_dis,
	output logic [5:0] bypass_stages,
	output logic auto_xover_en,
	output logic polarity_corr_en,
	output logic legacy_detect_en,
	output logic honor_adv_ability,
	output logic pulse_shape_en,
	output logic auto_np_en,
	output logic ten_link_sm_dis,
	output logic ten_jabber_dis,
	output logic ten_echo_dis,
	output logic ten_sqe_dis,
	output logic [1:0] ten_squelch_sel,
	output logic carrier_sense,
	output logic irq
);

	// ================================================================
	// storage
	logic [15:0] bypass_control;
	logic [15:0] ten_ctrl;
	logic [7:0] gig_flags;
	logic [1:0] ten_flags;
	logic [7:0] cnt [3];
	logic [`PESC_IRQ_W-1:0] irq_stat;
	logic [`PESC_IRQ_W-1:0] irq_mask;
	pesc_state_e state;

	// ================================================================
	// bus decode
	wire logic req = wb_cyc_i && wb_stb_i && (state == PESC_ST_IDLE);
	wire logic [4:0] idx = wb_adr_i[6:2];
	wire logic hit = (wb_adr_i[1:0] == 2'b00) && !wb_adr_i[7] && (idx == `PESC_IDX_GSTAT
		|| idx == `PESC_IDX_BYP || idx == `PESC_IDX_RXERR || idx == `PESC_IDX_FCAR
		|| idx == `PESC_IDX_LDROP || idx == `PESC_IDX_TENC
		|| idx == `PESC_IDX_IRQ_STAT || idx == `PESC_IDX_IRQ_MASK);
	wire logic rd = req && hit && !wb_we_i;
	wire logic wr_lo = req && hit && wb_we_i && wb_sel_i[0];
	wire logic wr_hi = req && hit && wb_we_i && wb_sel_i[1];

	function automatic logic sel_idx(input logic [4:0] a, input logic [4:0] b);
		sel_idx = (a == b);
	endfunction

	wire logic rd_gstat = rd && sel_idx(idx, `PESC_IDX_GSTAT);
	wire logic rd_tenc = rd && sel_idx(idx, `PESC_IDX_TENC);
	wire logic rd_istat = rd && sel_idx(idx, `PESC_IDX_IRQ_STAT);
	wire logic [2:0] rd_cnt = {rd && sel_idx(idx, `PESC_IDX_LDROP),
		rd && sel_idx(idx, `PESC_IDX_FCAR), rd && sel_idx(idx, `PESC_IDX_RXERR)};
	wire logic [15:0] wmask = {{8{wr_hi}}, {8{wr_lo}}};

	// merged write data for writable registers; reserved bits stay zero
	wire logic [15:0] next_byp = ((bypass_control & ~wmask) | (wb_dat_i[15:0] & wmask))
		& `PESC_BYP_WMASK;
	wire logic [15:0] next_tenc = ((ten_ctrl & ~wmask) | (wb_dat_i[15:0] & wmask))
		& `PESC_TENC_WMASK;

	// read mux, reserved positions read zero
	wire logic [15:0] gstat_val = {gig_dscr_locked, gig_flags[7:6], gig_link_up,
		gig_flags[5:2], gig_flags[1], legacy_partner_det, mdi_xover_err, 5'h00};
	wire logic [15:0] tenc_val = ten_ctrl | {7'h00, ten_flags, ten_link_up, 6'h00};
	logic [15:0] rdata;
	always_comb begin
		case (idx)
			`PESC_IDX_GSTAT: rdata = gstat_val;
			`PESC_IDX_BYP: rdata = bypass_control;
			`PESC_IDX_RXERR: rdata = {8'h00, cnt[0]};
			`PESC_IDX_FCAR: rdata = {8'h00, cnt[1]};
			`PESC_IDX_LDROP: rdata = {8'h00, cnt[2]};
			`PESC_IDX_TENC: rdata = tenc_val;
			`PESC_IDX_IRQ_STAT: rdata = {12'h000, irq_stat};
			`PESC_IDX_IRQ_MASK: rdata = {12'h000, irq_mask};
			default: rdata = 16'h0000;
		endcase
	end

	// ================================================================
	// wishbone slave: answer one cycle after the request, then drop ack
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= PESC_ST_IDLE;
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req && hit;
			wb_err_o <= req && !hit;
			wb_dat_o <= rd ? {16'h0000, rdata} : 32'h0000_0000;
			state <= req ? PESC_ST_ACK : PESC_ST_IDLE;
		end
	end

	// ================================================================
	// control registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bypass_control <= `PESC_BYP_RST;
			ten_ctrl <= `PESC_TENC_RST;
			irq_mask <= '0;
		end else begin
			if (sel_idx(idx, `PESC_IDX_BYP)) bypass_control <= next_byp;
			if (sel_idx(idx, `PESC_IDX_TENC)) ten_ctrl <= next_tenc;
			if (wr_lo && sel_idx(idx, `PESC_IDX_IRQ_MASK)) irq_mask <= wb_dat_i[3:0];
		end
	end

	// ================================================================
	// sticky flags: a new event in the read cycle wins over the clear
	wire logic [7:0] gig_evt = {gig_dscr_lock_err, gig_link_disc, gig_rx_err,
		gig_tx_err, gig_ssd_err, gig_esd_err, gig_cext_err, 1'b0};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gig_flags <= 8'h00;
			ten_flags <= 2'b00;
		end else begin
			gig_flags <= ((rd_gstat ? 8'h00 : gig_flags) | gig_evt) & 8'hFE;
			ten_flags <= (rd_tenc ? 2'b00 : ten_flags) | {ten_eof_err, ten_disc};
		end
	end

	// ================================================================
	// saturating counters, cleared on read; event in read cycle counts 1
	wire logic link_up_any = gig_link_up || fast_link_up;
	wire logic [2:0] cnt_evt = {link_drop_evt, false_carrier_evt && link_up_any,
		rx_err_evt && link_up_any};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_cnt
			wire logic [7:0] base = rd_cnt[gi] ? 8'h00 : cnt[gi];
			wire logic [7:0] next_cnt = (cnt_evt[gi] && base != `PESC_CNT_MAX) ?
				8'(base + 8'h01) : base;
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) cnt[gi] <= 8'h00;
				else cnt[gi] <= next_cnt;
			end
		end
	endgenerate

	// ================================================================
	// interrupt: status bits {link drop, false carrier, rx err, gig flag}
	wire logic [3:0] irq_evt = {cnt_evt[2], cnt_evt[1], cnt_evt[0], |gig_evt};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat <= (rd_istat ? 4'h0 : irq_stat) | irq_evt;
			irq <= |(((rd_istat ? 4'h0 : irq_stat) | irq_evt) & irq_mask);
		end
	end

	// ================================================================
	// datapath controls and carrier sense, registered
	logic next_crs;
	always_comb begin
		case (pesc_cs_e'(ten_ctrl[`PESC_TEN_CS_HI:`PESC_TEN_CS_LO]))
			PESC_CS_RX_OR_HDXTX: next_crs = receiving || (transmitting && !full_duplex_flag);
			PESC_CS_ANY_HDX: next_crs = (receiving || transmitting) && !full_duplex_flag;
			PESC_CS_RX_ONLY: next_crs = receiving;
			PESC_CS_RX_HDX: next_crs = receiving && !full_duplex_flag;
			default: next_crs = receiving;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_media_dis <= 1'b0;
			bypass_stages <= 6'h00;
			auto_xover_en <= 1'b1;
			polarity_corr_en <= 1'b1;
			legacy_detect_en <= 1'b1;
			honor_adv_ability <= 1'b1;
			pulse_shape_en <= 1'b1;
			auto_np_en <= 1'b1;
			ten_link_sm_dis <= 1'b0;
			ten_jabber_dis <= 1'b0;
			ten_echo_dis <= 1'b1;
			ten_sqe_dis <= 1'b1;
			ten_squelch_sel <= 2'b00;
			carrier_sense <= 1'b0;
		end else begin
			tx_media_dis <= bypass_control[`PESC_BYP_TXDIS];
			bypass_stages <= bypass_control[`PESC_BYP_4B5B:`PESC_BYP_LFIT];
			auto_xover_en <= !bypass_control[`PESC_BYP_MDIXDIS]
				&& !(speed_forced && bypass_control[`PESC_BYP_XFORCE]);
			polarity_corr_en <= !bypass_control[`PESC_BYP_POLDIS];
			legacy_detect_en <= !bypass_control[`PESC_BYP_LEGDIS];
			honor_adv_ability <= bypass_control[`PESC_BYP_HONOR];
			pulse_shape_en <= !bypass_control[`PESC_BYP_PSFDIS];
			auto_np_en <= !bypass_control[`PESC_BYP_NPDIS];
			ten_link_sm_dis <= ten_ctrl[`PESC_TEN_LIDIS];
			ten_jabber_dis <= ten_ctrl[`PESC_TEN_JABDIS];
			ten_echo_dis <= ten_ctrl[`PESC_TEN_ECHODIS];
			ten_sqe_dis <= ten_ctrl[`PESC_TEN_SQEDIS];
			ten_squelch_sel <= ten_ctrl[`PESC_TEN_SQ_HI:`PESC_TEN_SQ_LO];
			carrier_sense <= next_crs;
		end
	end

	// ================================================================
	// assertions
	a_rxerr_saturate: assert property (@(posedge clk) disable iff (!arst_n)
		cnt[0] == 8'hFF && !rd_cnt[0] |=> cnt[0] == 8'hFF) else $error("rx err count left max");
	a_fcar_count: assert property (@(posedge clk) disable iff (!arst_n)
		cnt_evt[1] && !rd_cnt[1] && cnt[1] < 8'hFF |=> cnt[1] == $past(cnt[1]) + 8'h01)
		else $error("false carrier did not count");
	a_ldrop_clear: assert property (@(posedge clk) disable iff (!arst_n)
		rd_cnt[2] && !link_drop_evt |=> cnt[2] == 8'h00) else $error("link drop not cleared");
	a_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
		gig_rx_err || (gig_flags[5] && !rd_gstat) |=> gig_flags[5])
		else $error("rx flag lost");
	a_flag_clear: assert property (@(posedge clk) disable iff (!arst_n)
		rd_gstat && !(|gig_evt) |=> gig_flags == 8'h00) else $error("flags not cleared");
	a_txdis_follow: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |=> tx_media_dis == $past(bypass_control[15])) else $error("tx disable lag");
	a_xover_forced: assert property (@(posedge clk) disable iff (!arst_n)
		speed_forced && bypass_control[7] |=> !auto_xover_en) else $error("xover in forced");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
		(bypass_control & ~16'hFEFE) == 16'h0000 && (ten_ctrl & ~16'hFE06) == 16'h0000)
		else $error("reserved bit set");
	a_crs_fdx: assert property (@(posedge clk) disable iff (!arst_n)
		ten_ctrl[2:1] == 2'b11 && full_duplex_flag |=> !carrier_sense)
		else $error("crs in full duplex");
	a_ack_one: assert property (@(posedge clk) disable iff (!arst_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held");
	c_cnt_sat: cover property (@(posedge clk) disable iff (!arst_n) cnt[0] == 8'hFF);
	c_rd_clear: cover property (@(posedge clk) disable iff (!arst_n) rd_cnt[1] && cnt[1] != 0);
	c_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));
	c_evt_on_rd: cover property (@(posedge clk) disable iff (!arst_n) rd_gstat && gig_rx_err);

endmodule
`default_nettype wire

// ### dv/pesc_host.sv
/*
 host model: classic wishbone master issuing single register cycles.
 assumes a slave that answers each cycle with ack or err.
*/
`timescale 1ns/10ps
`default_nettype none
module pesc_host (
	input wire logic clk,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic [31:0] rdat,
	input wire logic ack,
	input wire logic err
);
	// ==========================================================
	// idle bus; released write data is inverted so it never looks held
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0000_0000;
	end

	// one cycle, held until ack or err is sampled, then one idle cycle;
	// no wait limit here, the bench timeout ends a hung cycle
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		dat <= {16'h0000, d};
		@(posedge clk);
		while (ack !== 1'b1 && err !== 1'b1) begin
			@(posedge clk);
		end
		q = rdat[15:0];
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		dat <= ~dat;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ### dv/pesc_regs_bench.sv
/*
 bench for the extended status register bank: register cycles go through
 the host model, event pulses and status levels are driven here.
 assumes package and header are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module pesc_regs_bench;
	// ==========================================================
	// stimulus and observation signals
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [11:0] ev = 12'h000;
	logic [9:0] lv = 10'h000;
	wire logic cyc, stb, we, ack, err, cs, irq;
	wire logic [7:0] adr;
	wire logic [3:0] sel, ten;
	wire logic [31:0] dat, rdat;
	wire logic [12:0] ctl;
	wire logic [1:0] sq;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int fbit[7] = '{14, 13, 11, 10, 9, 8, 7};
	logic [15:0] q;
	logic e;

	always #10 clk = ~clk;

	pesc_host i_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dat(dat), .rdat(rdat), .ack(ack), .err(err));

	pesc_regs i_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(err), .gig_link_up(lv[0]), .fast_link_up(lv[1]),
		.gig_dscr_locked(lv[2]), .gig_dscr_lock_err(ev[0]), .gig_link_disc(ev[1]),
		.gig_rx_err(ev[2]), .gig_tx_err(ev[3]), .gig_ssd_err(ev[4]), .gig_esd_err(ev[5]),
		.gig_cext_err(ev[6]), .legacy_partner_det(lv[3]), .mdi_xover_err(lv[4]),
		.rx_err_evt(ev[7]), .false_carrier_evt(ev[8]), .link_drop_evt(ev[9]),
		.ten_eof_err(ev[10]), .ten_disc(ev[11]), .ten_link_up(lv[5]), .speed_forced(lv[6]),
		.receiving(lv[7]), .transmitting(lv[8]), .full_duplex_flag(lv[9]),
		.tx_media_dis(ctl[12]), .bypass_stages(ctl[11:6]), .auto_xover_en(ctl[5]),
		.polarity_corr_en(ctl[4]), .legacy_detect_en(ctl[3]), .honor_adv_ability(ctl[2]),
		.pulse_shape_en(ctl[1]), .auto_np_en(ctl[0]), .ten_link_sm_dis(ten[3]),
		.ten_jabber_dis(ten[2]), .ten_echo_dis(ten[1]), .ten_sqe_dis(ten[0]),
		.ten_squelch_sel(sq), .carrier_sense(cs), .irq(irq));

	// ==========================================================
	// checking and access helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		i_host.xfer(1'b0, a, 16'h0000, q, e);
		chk(q, exp, "register read");
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_host.xfer(1'b1, a, d, q, e);
	endtask

	// hold one event input high for k cycles, each cycle counts once
	task automatic pulse(input int b, input int k);
		ev[b] <= 1'b1;
		repeat (k) @(posedge clk);
		ev[b] <= 1'b0;
		@(posedge clk);
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
	endtask

	// expected carrier sense from mode and {full duplex, transmitting, receiving}
	function automatic logic csx(input int m, input logic [2:0] v);
		case (m)
			0: csx = v[0] | (v[1] & ~v[2]);
			1: csx = (v[0] | v[1]) & ~v[2];
			2: csx = v[0];
			default: csx = v[0] & ~v[2];
		endcase
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(8'h48, 16'h0088);
		rd(8'h58, 16'h3200);
		chk({3'b000, ctl}, 16'h003F, "control defaults");
		chk({12'h000, ten}, 16'h0003, "ten defaults");
		$display("reset test done");
		wr(8'h48, 16'hFFFF);
		rd(8'h48, 16'hFEFE);
		settle();
		chk({3'b000, ctl}, 16'h1FC4, "bypass all set");
		wr(8'h48, 16'h0000);
		settle();
		chk({3'b000, ctl}, 16'h003B, "bypass all clear");
		wr(8'h48, 16'h0080);
		lv[6] <= 1'b1;
		settle();
		chk({15'h0000, ctl[5]}, 16'h0000, "forced crossover");
		lv[6] <= 1'b0;
		settle();
		chk({15'h0000, ctl[5]}, 16'h0001, "auto crossover");
		wr(8'h58, 16'hFFFF);
		rd(8'h58, 16'hFE06);
		chk({12'h000, ten}, 16'h000F, "ten disables");
		for (int m = 0; m < 4; m++) begin
			wr(8'h58, 16'(m << 10) | 16'(m << 1));
			for (int c = 0; c < 2; c++) begin
				lv[9:7] <= (c == 0) ? 3'b010 : 3'b101;
				settle();
				chk({15'h0000, cs}, {15'h0000, csx(m, lv[9:7])}, "carrier sense");
				chk({14'h0000, sq}, 16'(m), "squelch select");
			end
		end
		// all levels idle except the gigabit link, one assignment per step
		lv <= 10'h001;
		$display("control test done");
		for (int c = 0; c < 3; c++) begin
			pulse(7 + c, 3);
			rd(8'h4C + 8'(4 * c), 16'h0003);
			rd(8'h4C + 8'(4 * c), 16'h0000);
			pulse(7 + c, 300);
			rd(8'h4C + 8'(4 * c), 16'h00FF);
		end
		lv[0] <= 1'b0;
		pulse(7, 2);
		pulse(8, 2);
		pulse(9, 2);
		rd(8'h4C, 16'h0000);
		rd(8'h50, 16'h0000);
		rd(8'h54, 16'h0002);
		lv[1] <= 1'b1;
		pulse(7, 1);
		rd(8'h4C, 16'h0001);
		$display("counter test done");
		for (int i = 0; i < 7; i++) begin
			pulse(i, 1);
			rd(8'h44, 16'(1 << fbit[i]));
			rd(8'h44, 16'h0000);
		end
		lv[4:0] <= 5'b11111;
		settle();
		rd(8'h44, 16'h9060);
		rd(8'h44, 16'h9060);
		i_host.xfer(1'b0, 8'h5C, 16'h0000, q, e);
		chk({15'h0000, e}, 16'h0001, "unmapped error");
		i_host.xfer(1'b0, 8'h45, 16'h0000, q, e);
		chk({15'h0000, e}, 16'h0001, "misaligned error");
		$display("status test done");
		i_host.xfer(1'b0, 8'h60, 16'h0000, q, e);
		wr(8'h64, 16'h0002);
		pulse(7, 1);
		settle();
		chk({15'h0000, irq}, 16'h0001, "irq raised");
		rd(8'h60, 16'h0002);
		settle();
		chk({15'h0000, irq}, 16'h0000, "irq cleared");
		wr(8'h64, 16'h0000);
		pulse(7, 1);
		settle();
		chk({15'h0000, irq}, 16'h0000, "irq masked");
		rd(8'h60, 16'h0002);
		$display("interrupt test done");
		test_done();
	end
endmodule
`default_nettype wire
